// ==== core/nic_map.svh ====
// offsets, field positions, reset values and vector constants of the nested priority block
// assumes inclusion by bare name from the design file and the bench
`ifndef NIC_MAP_SVH
`define NIC_MAP_SVH
// register indices; byte address is four times the index
`define NIC_IDX_CC      6'h20
`define NIC_IDX_IRQ_PRIORITY_0   6'h24
`define NIC_IDX_IRQ_PRIORITY_1   6'h25
`define NIC_IDX_IRQ_PRIORITY_2   6'h26
`define NIC_IDX_IRQ_PRIORITY_3   6'h27
`define NIC_IDX_EXT_IRQ_CTRL    6'h28
// reset values and the read-only ones of the fourth priority register
`define NIC_CC_RST      8'hea
`define NIC_ISPR_RST    8'hff
`define NIC_EXT_IRQ_CTRL_RST    8'h00
`define NIC_IRQ_PRIORITY_3_RO    8'hf0
// condition-code priority bit positions and codes
`define NIC_CC_HI       5
`define NIC_CC_LO       3
`define NIC_CODE_L0     2'b10
`define NIC_CODE_L3     2'b11
// external control field positions
`define NIC_EI_IS1      6
`define NIC_EI_IPB      5
`define NIC_EI_IS2      3
`define NIC_EI_IPA      2
`define NIC_EI_TLIS     1
`define NIC_EI_TLIE     0
// vectors and wake capability per source number
`define NIC_VEC_TLI     16'hfffa
`define NIC_WAKE_HALT   14'h20bd
`define NIC_WAKE_AHALT  14'h20bf
`define NIC_WAKE_RUN    14'h3fff
`endif

// ==== core/nic_pkg.sv ====
// types shared by the nested priority block and its neighbours
// assumes nothing beyond a SystemVerilog compiler
package nic_pkg;
  typedef enum logic [2:0] {
    NIC_OP_RIM   = 3'b000,
    NIC_OP_SIM   = 3'b001,
    NIC_OP_HALT  = 3'b010,
    NIC_OP_WFI   = 3'b011,
    NIC_OP_TRAP  = 3'b100,
    NIC_OP_IRQ_RETURN_INSTR  = 3'b101,
    NIC_OP_POPCC = 3'b110
  } nic_op_e;

  typedef struct packed {
    logic       valid;
    nic_op_e    op;
    logic [7:0] cc_val;
  } nic_cpu_evt_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  src;
    logic [15:0] addr;
  } nic_vec_s;
endpackage : nic_pkg

// ==== core/nic_ctrl.sv ====
// nested interrupt priority controller: condition-code priority bits, per-vector
// software priority, external sensitivity, arbitration and halt wake-up
// assumes a classic Wishbone master on CLK and a CPU core that pulses its events on CLK
//
// Overview of operation
// - current priority lives in condition-code bits 5 and 3
// - codes: level0=10, level1=01, level2=00, level3=11 (masked)
// - condition codes reset to 111x1010, level 3
// - interrupt entry loads current priority from that vector's stored pair
// - enable, disable, halt, wait, return and pop instructions alter priority bits
// - top-level, trap and reset act even at level 3
// - priority registers reset to ff; upper nibble of fourth reads ones
// - pair n belongs to vector fffa minus 2n, down to pair 13
// - writing code 10 into a pair leaves that pair unchanged
// - top-level, reset and trap entries set level 3
// - top-level pair is storage only, ignored by arbitration
// - raising a pending routine's pair above current level re-enters it
// - enable, wait and halt load code 10
// - disable and trap load code 11
// - masked flag tells jump instructions whether level is 3
// - instruction-set level persists until return or next such instruction
// - fixed vector order; lower source number wins in hardware
// - only listed sources wake from halt
// - clock time-base source wakes only from active halt
// - four edge/level modes; rising with high level only on groups a and b-low
// - four external groups; a and f share one sensitivity field, b-low and b-high the other
// - sensitivity bits change only at level 3
// - changing sensitivity clears all pending external requests
// - highest software level first, ties to highest hardware priority
// - maskable request served only above current level, else stays pending
//
// Our own choices: register access over Wishbone and the address map.
`include "nic_map.svh"

module nic_ctrl
  import nic_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         SRST,
  input  wire logic         WB_CYC_I,
  input  wire logic         WB_STB_I,
  input  wire logic         WB_WE_I,
  input  wire logic [7:0]   WB_ADR_I,
  input  wire logic [3:0]   WB_SEL_I,
  input  wire logic [31:0]  WB_DAT_I,
  output logic      [31:0]  WB_DAT_O,
  output logic              WB_ACK_O,
  input  wire nic_cpu_evt_s CPU_EVT,
  input  wire logic         VEC_ACK,
  input  wire logic         CLK_TB_REQ,
  input  wire logic [6:0]   PERIPH_REQ,
  input  wire logic         TLI_PIN,
  input  wire logic [3:0]   PORT_A,
  input  wire logic [2:0]   PORT_F,
  input  wire logic [7:0]   PORT_B,
  input  wire logic         HALT_MODE,
  input  wire logic         ACTIVE_HALT,
  output nic_vec_s          VEC,
  output logic              WAKE,
  output logic              MASKED
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] lvl_of(input logic [1:0] code);
    case (code)
      2'b10:   lvl_of = 2'd0;
      2'b01:   lvl_of = 2'd1;
      2'b00:   lvl_of = 2'd2;
      default: lvl_of = 2'd3;
    endcase
  endfunction : lvl_of

  function automatic logic [7:0] ispr_merge(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = wr;
    for (int p = 0; p < 4; p++) begin
      if (wr[2*p +: 2] == `NIC_CODE_L0) begin
        res[2*p +: 2] = old[2*p +: 2];
      end
    end
    ispr_merge = res;
  endfunction : ispr_merge

  // edge enables per sensitivity code; polarity swaps edges except in both-edge mode
  function automatic logic ext_evt(input logic [1:0] is, input logic pol, input logic rise,
                                   input logic fall);
    logic r_en;
    logic f_en;
    r_en = 1'b1;
    f_en = 1'b1;
    case (is)
      2'b01:   begin r_en = ~pol; f_en = pol; end
      2'b11:   begin r_en = 1'b1; f_en = 1'b1; end
      default: begin r_en = pol;  f_en = ~pol; end
    endcase
    ext_evt = (r_en & rise) | (f_en & fall);
  endfunction : ext_evt

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  cc;
  logic [7:0]  ispr [4];
  logic [7:0]  ext_irq_ctrl;
  logic [31:0] ispr_flat;
  logic [1:0]  cur_code;
  logic [1:0]  cur_lvl;
  logic        lvl3;
  logic [15:0] pin_s1;
  logic [15:0] pin_s2;
  logic [15:0] pin_s3;
  logic [15:0] rise_v;
  logic [15:0] fall_v;
  logic [3:0]  g_r;
  logic [3:0]  g_f;
  logic [3:0]  g_lo;
  logic [3:0]  g_hi;
  logic [3:0]  ext_set;
  logic [3:0]  ext_lvl;
  logic [3:0]  ext_pend;
  logic [3:0]  ext_req;
  logic [3:0]  ext_clr;
  logic        tli_pend;
  logic        tli_evt;
  logic [13:0] req;
  logic [13:0] wmask;
  logic        take;
  logic [1:0]  ent_code;
  nic_vec_s    next_vec;
  logic        best_ok;
  logic [1:0]  best_lvl;
  logic [3:0]  best_src;
  logic        wb_req;
  logic        wb_wr;
  logic [5:0]  idx;
  logic        ext_irq_ctrl_chg;
  logic [7:0]  rd_data;

  assign ispr_flat = {ispr[3], ispr[2], ispr[1], ispr[0]};
  assign cur_code  = {cc[`NIC_CC_HI], cc[`NIC_CC_LO]};
  assign cur_lvl   = lvl_of(cur_code);
  assign lvl3      = (cur_code == `NIC_CODE_L3);
  assign take      = VEC_ACK & VEC.valid;
  assign ent_code  = (VEC.src == 4'h0) ? `NIC_CODE_L3 : ispr_flat[{VEC.src, 1'b0} +: 2];

  // ****************************************
  // wishbone slave
  // ****************************************
  // one wait state: ack the cycle after the request, commit writes on the ack edge
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr  = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & WB_SEL_I[0] & (WB_ADR_I[1:0] == 2'b00);
  assign idx    = WB_ADR_I[7:2];

  always_comb begin
    rd_data = 8'h00;
    if (WB_ADR_I[1:0] == 2'b00) begin
      case (idx)
        `NIC_IDX_CC:    rd_data = cc;
        `NIC_IDX_IRQ_PRIORITY_0: rd_data = ispr[0];
        `NIC_IDX_IRQ_PRIORITY_1: rd_data = ispr[1];
        `NIC_IDX_IRQ_PRIORITY_2: rd_data = ispr[2];
        `NIC_IDX_IRQ_PRIORITY_3: rd_data = ispr[3] | `NIC_IRQ_PRIORITY_3_RO;
        `NIC_IDX_EXT_IRQ_CTRL:  rd_data = ext_irq_ctrl;
        default:        rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? {24'h0, rd_data} : 32'h0;
    end
  end

  // ****************************************
  // condition codes
  // ****************************************
  // entry beats an instruction event, which beats a bus write
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cc <= `NIC_CC_RST;
    end else if (take) begin
      {cc[`NIC_CC_HI], cc[`NIC_CC_LO]} <= ent_code;
    end else if (CPU_EVT.valid) begin
      case (CPU_EVT.op)
        NIC_OP_RIM, NIC_OP_WFI, NIC_OP_HALT: {cc[`NIC_CC_HI], cc[`NIC_CC_LO]} <= `NIC_CODE_L0;
        NIC_OP_SIM, NIC_OP_TRAP: {cc[`NIC_CC_HI], cc[`NIC_CC_LO]} <= `NIC_CODE_L3;
        NIC_OP_IRQ_RETURN_INSTR, NIC_OP_POPCC: cc <= CPU_EVT.cc_val;
        default: cc <= cc;
      endcase
    end else if (wb_wr && idx == `NIC_IDX_CC) begin
      cc <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      MASKED <= 1'b1;
    end else begin
      MASKED <= lvl3;
    end
  end

  // ****************************************
  // software priority registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int k = 0; k < 4; k++) begin
        ispr[k] <= `NIC_ISPR_RST;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (wb_wr && idx == 6'(`NIC_IDX_IRQ_PRIORITY_0 + k)) begin
          ispr[k] <= ispr_merge(ispr[k], WB_DAT_I[7:0]) | ((k == 3) ? `NIC_IRQ_PRIORITY_3_RO : 8'h00);
        end
      end
    end
  end

  // ****************************************
  // external control register
  // ****************************************
  assign ext_irq_ctrl_chg = wb_wr && idx == `NIC_IDX_EXT_IRQ_CTRL && lvl3 && (WB_DAT_I[7:2] != ext_irq_ctrl[7:2]);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ext_irq_ctrl <= `NIC_EXT_IRQ_CTRL_RST;
    end else if (wb_wr && idx == `NIC_IDX_EXT_IRQ_CTRL) begin
      if (lvl3) begin
        ext_irq_ctrl[7:2] <= WB_DAT_I[7:2];
      end
      if (!ext_irq_ctrl[`NIC_EI_TLIE]) begin
        ext_irq_ctrl[`NIC_EI_TLIS] <= WB_DAT_I[`NIC_EI_TLIS];
      end
      ext_irq_ctrl[`NIC_EI_TLIE] <= WB_DAT_I[`NIC_EI_TLIE];
    end
  end

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  // pins are asynchronous; the third stage only serves edge detection
  always_ff @(posedge CLK) begin
    pin_s1 <= {TLI_PIN, PORT_B, PORT_F, PORT_A};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  assign rise_v = pin_s2 & ~pin_s3;
  assign fall_v = ~pin_s2 & pin_s3;
  // pins of one group are ored together
  assign g_r  = {|rise_v[14:11], |rise_v[10:7], |rise_v[6:4], |rise_v[3:0]};
  assign g_f  = {|fall_v[14:11], |fall_v[10:7], |fall_v[6:4], |fall_v[3:0]};
  assign g_lo = {~&pin_s2[14:11], ~&pin_s2[10:7], ~&pin_s2[6:4], ~&pin_s2[3:0]};
  assign g_hi = {|pin_s2[14:11], |pin_s2[10:7], |pin_s2[6:4], |pin_s2[3:0]};

  always_comb begin
    // groups: 0 port a (polarity a), 1 port f, 2 port b low (polarity b), 3 port b high
    ext_set[0] = ext_evt(ext_irq_ctrl[`NIC_EI_IS2 +: 2], ext_irq_ctrl[`NIC_EI_IPA], g_r[0], g_f[0]);
    ext_set[1] = ext_evt(ext_irq_ctrl[`NIC_EI_IS2 +: 2], 1'b0, g_r[1], g_f[1]);
    ext_set[2] = ext_evt(ext_irq_ctrl[`NIC_EI_IS1 +: 2], ext_irq_ctrl[`NIC_EI_IPB], g_r[2], g_f[2]);
    ext_set[3] = ext_evt(ext_irq_ctrl[`NIC_EI_IS1 +: 2], 1'b0, g_r[3], g_f[3]);
    ext_lvl[0] = (ext_irq_ctrl[`NIC_EI_IS2 +: 2] == 2'b00) && (ext_irq_ctrl[`NIC_EI_IPA] ? g_hi[0] : g_lo[0]);
    ext_lvl[1] = (ext_irq_ctrl[`NIC_EI_IS2 +: 2] == 2'b00) && g_lo[1];
    ext_lvl[2] = (ext_irq_ctrl[`NIC_EI_IS1 +: 2] == 2'b00) && (ext_irq_ctrl[`NIC_EI_IPB] ? g_hi[2] : g_lo[2]);
    ext_lvl[3] = (ext_irq_ctrl[`NIC_EI_IS1 +: 2] == 2'b00) && g_lo[3];
    ext_clr = {4{ext_irq_ctrl_chg}};
    for (int g = 0; g < 4; g++) begin
      if (take && VEC.src == 4'(g + 2)) begin
        ext_clr[g] = 1'b1;
      end
    end
  end

  // a fresh edge in the clearing cycle survives
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ext_pend <= 4'h0;
    end else begin
      ext_pend <= ext_set | (ext_pend & ~ext_clr);
    end
  end

  assign ext_req = ext_pend | ext_lvl;
  assign tli_evt = ext_irq_ctrl[`NIC_EI_TLIE] & (ext_irq_ctrl[`NIC_EI_TLIS] ? rise_v[15] : fall_v[15]);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      tli_pend <= 1'b0;
    end else begin
      tli_pend <= tli_evt | (tli_pend & ~(take && VEC.src == 4'h0));
    end
  end

  // ****************************************
  // arbitration
  // ****************************************
  // peripheral requests are level flags held by their owners until cleared there
  assign req = {PERIPH_REQ, 1'b0, ext_req, CLK_TB_REQ, tli_pend};

  always_comb begin
    wmask = HALT_MODE ? (ACTIVE_HALT ? `NIC_WAKE_AHALT : `NIC_WAKE_HALT) : `NIC_WAKE_RUN;
    best_ok  = 1'b0;
    best_lvl = 2'd0;
    best_src = 4'h0;
    // live pairs and live level give re-entry when a pending pair is raised
    for (int i = 13; i >= 1; i--) begin
      if (req[i] && wmask[i] && lvl_of(ispr_flat[2*i +: 2]) > cur_lvl &&
          (!best_ok || lvl_of(ispr_flat[2*i +: 2]) >= best_lvl)) begin
        best_ok  = 1'b1;
        best_lvl = lvl_of(ispr_flat[2*i +: 2]);
        best_src = 4'(i);
      end
    end
    next_vec.valid = best_ok;
    next_vec.src   = best_src;
    if (req[0] && wmask[0]) begin
      next_vec.valid = 1'b1;
      next_vec.src   = 4'h0;
    end
    next_vec.addr = 16'(`NIC_VEC_TLI - {11'h0, next_vec.src, 1'b0});
  end

  // the offer is withdrawn for a cycle after acceptance so it reflects the new level
  always_ff @(posedge CLK) begin
    if (SRST) begin
      VEC <= '0;
    end else if (take) begin
      VEC <= '0;
    end else begin
      VEC <= next_vec;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= HALT_MODE & |(req & wmask);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  property p_wb_ack;
    s_wb_req |=> s_ack_pulse;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle after request");

  property p_cc_reset;
    $fell(SRST) |-> cc == `NIC_CC_RST && MASKED;
  endproperty
  a_cc_reset: assert property (p_cc_reset) else $error("condition codes wrong after reset");

  property p_irq_priority_3_top;
    ispr[3][7:4] == 4'hf;
  endproperty
  a_irq_priority_3_top: assert property (p_irq_priority_3_top) else $error("fourth priority register top not ones");

  property p_lvl0_kept;
    wb_wr && idx == `NIC_IDX_IRQ_PRIORITY_0 && WB_DAT_I[1:0] == `NIC_CODE_L0 |=> ispr[0][1:0] == $past(ispr[0][1:0]);
  endproperty
  a_lvl0_kept: assert property (p_lvl0_kept) else $error("level 0 code was stored");

  property p_entry_load;
    take && VEC.src != 4'h0 |=> cur_code == $past(ent_code) && !VEC.valid;
  endproperty
  a_entry_load: assert property (p_entry_load) else $error("entry did not load vector priority");

  property p_tli_l3;
    take && VEC.src == 4'h0 |=> lvl3 ##1 MASKED;
  endproperty
  a_tli_l3: assert property (p_tli_l3) else $error("top-level entry not at level 3");

  sequence s_sim;
    CPU_EVT.valid && CPU_EVT.op == NIC_OP_SIM && !take;
  endsequence
  property p_sim;
    s_sim |=> lvl3 ##1 MASKED;
  endproperty
  a_sim: assert property (p_sim) else $error("disable did not mask");

  property p_rim;
    CPU_EVT.valid && CPU_EVT.op inside {NIC_OP_RIM, NIC_OP_WFI, NIC_OP_HALT} && !take
      |=> cur_code == `NIC_CODE_L0 ##1 !MASKED;
  endproperty
  a_rim: assert property (p_rim) else $error("enable did not load level 0");

  property p_ext_irq_ctrl_lock;
    wb_wr && idx == `NIC_IDX_EXT_IRQ_CTRL && !lvl3 |=> $stable(ext_irq_ctrl[7:2]);
  endproperty
  a_ext_irq_ctrl_lock: assert property (p_ext_irq_ctrl_lock) else $error("sensitivity changed below level 3");

  property p_ext_irq_ctrl_clr;
    ext_irq_ctrl_chg && ext_set == 4'h0 |=> ext_pend == 4'h0;
  endproperty
  a_ext_irq_ctrl_clr: assert property (p_ext_irq_ctrl_clr) else $error("pending not cleared on change");

  property p_arb;
    VEC.valid && VEC.src != 4'h0 && !$past(take)
      |-> lvl_of(2'($past(ispr_flat) >> {VEC.src, 1'b0})) > $past(cur_lvl);
  endproperty
  a_arb: assert property (p_arb) else $error("offered vector not above current level");

  property p_wake;
    WAKE |-> $past(HALT_MODE) && !(!$past(ACTIVE_HALT) && $past(req) == 14'h0002);
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside halt or from excluded source");

endmodule : nic_ctrl

// ==== tb/nic_cpu_model.sv ====
// cpu-side partner: takes each offered vector after a chosen delay
// assumes the controller's vector port on the same clock and reset
module nic_cpu_model
  import nic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire nic_vec_s   vec,
  input  wire logic [1:0] dly,
  output logic            vec_ack,
  output logic [3:0]      got_src,
  output logic [15:0]     got_addr,
  output int              n_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;

  // acks only a standing offer, never on two edges running
  always_ff @(posedge clk) begin
    if (srst) begin
      vec_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (vec_ack) begin
      vec_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (vec.valid && wait_cnt >= dly) begin
      vec_ack <= 1'b1;
    end else if (vec.valid) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // what was really taken: offer and ack both high at one edge
  always_ff @(posedge clk) begin
    if (srst) begin
      n_taken <= 0;
    end else if (vec_ack && vec.valid) begin
      got_src  <= vec.src;
      got_addr <= vec.addr;
      n_taken  <= n_taken + 1;
    end
  end
endmodule : nic_cpu_model

// ==== tb/tb_nic_ctrl.sv ====
// self-checking bench for the nested priority controller
// assumes the core files and nic_map.svh on the include path
`include "nic_map.svh"
module tb_nic_ctrl;
  import nic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    nic_op_e    op;
    logic [7:0] ccv;
    logic [1:0] code;
  } nic_row_s;
  localparam logic [7:0] a_cc  = {`NIC_IDX_CC, 2'b00};
  localparam logic [7:0] a_pr0 = {`NIC_IDX_IRQ_PRIORITY_0, 2'b00};
  localparam logic [7:0] a_ext = {`NIC_IDX_EXT_IRQ_CTRL, 2'b00};
  logic         CLK, SRST, cyc, stb, we, ack, vec_ack, wake, masked, top_level_irq, clk_tb, halt, act;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat, q;
  logic [6:0]   periph;
  logic [3:0]   port_a, got_src;
  logic [15:0]  got_addr;
  logic [1:0]   dly;
  int           n_taken, bad_count, checks_done;
  nic_cpu_evt_s evt;
  nic_vec_s     vec;
  nic_row_s     rows[8];

  nic_ctrl dut (.CLK(CLK), .SRST(SRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CPU_EVT(evt), .VEC_ACK(vec_ack),
    .CLK_TB_REQ(clk_tb), .PERIPH_REQ(periph), .TLI_PIN(top_level_irq), .PORT_A(port_a), .PORT_F(3'h7),
    .PORT_B(8'hff), .HALT_MODE(halt), .ACTIVE_HALT(act), .VEC(vec), .WAKE(wake), .MASKED(masked));
  nic_cpu_model cpu_side (.clk(CLK), .srst(SRST), .vec(vec), .dly(dly), .vec_ack(vec_ack),
    .got_src(got_src), .got_addr(got_addr), .n_taken(n_taken));

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %0t %s", $time, msg);
      bad_count++;
    end
  endtask : chk

  // no cycle count assumed: only the watchdog ends a lost ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do @(posedge CLK); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h0, e}, "register read");
  endtask : rd_chk

  task automatic cc_chk(input logic [1:0] code);
    wb(1'b0, a_cc, 8'h00);
    chk(32'({q[5], q[3]}), 32'(code), "cc priority bits");
  endtask : cc_chk

  task automatic cpu(input nic_op_e op, input logic [7:0] v);
    @(posedge CLK);
    evt <= '{valid: 1'b1, op: op, cc_val: v};
    @(posedge CLK);
    evt.valid <= 1'b0;
  endtask : cpu

  task automatic take(input logic [3:0] s, input logic [15:0] a);
    int n0;
    n0 = n_taken;
    while (n_taken == n0) @(posedge CLK);
    chk({12'h0, got_src, got_addr}, {12'h0, s, a}, "vector taken");
  endtask : take

  task automatic no_vec(input int n);
    repeat (n) begin
      @(posedge CLK);
      chk(32'(vec.valid), 32'h0, "vector offered");
    end
  endtask : no_vec

  task automatic pulse_a();
    @(posedge CLK);
    port_a <= 4'he;
    repeat (2) @(posedge CLK);
    port_a <= 4'hf;
    repeat (6) @(posedge CLK);
  endtask : pulse_a

  task automatic wake_chk(input logic c, input logic [6:0] p, input logic a, input logic e);
    @(posedge CLK);
    halt   <= 1'b1;
    clk_tb <= c;
    periph <= p;
    act    <= a;
    repeat (4) @(posedge CLK);
    chk(32'(wake), 32'(e), "wake");
    halt   <= 1'b0;
    clk_tb <= 1'b0;
    periph <= 7'h0;
    act    <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask : wake_chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // ****************
  // clock, watchdog
  // ****************
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    conclude();
  end

  // ****************
  // tests
  // ****************
  initial begin
    {SRST, cyc, stb, we, top_level_irq, clk_tb, halt, act} = 8'h88;
    {adr, wdat, periph, port_a, dly} = '0;
    port_a = 4'hf;
    evt = '0;
    rows = '{'{NIC_OP_RIM, 8'h00, 2'b10}, '{NIC_OP_IRQ_RETURN_INSTR, 8'h08, 2'b01}, '{NIC_OP_SIM, 8'h00, 2'b11},
      '{NIC_OP_HALT, 8'h00, 2'b10}, '{NIC_OP_POPCC, 8'h00, 2'b00}, '{NIC_OP_TRAP, 8'h00, 2'b11},
      '{NIC_OP_WFI, 8'h00, 2'b10}, '{NIC_OP_SIM, 8'h00, 2'b11}};
    // three edges fill the pin pipeline
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    chk(32'(masked), 32'h1, "masked after reset");
    rd_chk(a_cc, 8'hea);
    for (int i = 0; i < 4; i++) rd_chk(a_pr0 + 8'(4 * i), 8'hff);
    rd_chk(a_ext, 8'h00);
    rd_chk(8'hfc, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      cpu(rows[i].op, rows[i].ccv);
      repeat (2) @(posedge CLK);
      chk(32'(masked), 32'(rows[i].code == 2'b11), "masked flag");
      cc_chk(rows[i].code);
    end
    $display("test ops done");
    wb(1'b1, a_pr0, 8'hcf);
    wb(1'b1, a_pr0, 8'h64);
    rd_chk(a_pr0, 8'h44);
    wb(1'b1, a_pr0 + 8'd12, 8'h00);
    rd_chk(a_pr0 + 8'd12, 8'hf0);
    $display("test pairs done");
    wb(1'b1, a_ext, 8'h01);
    top_level_irq <= 1'b0;
    take(4'h0, `NIC_VEC_TLI);
    top_level_irq <= 1'b1;
    cc_chk(2'b11);
    $display("test top level done");
    wb(1'b1, a_ext, 8'h11);
    pulse_a();
    no_vec(8);
    cpu(NIC_OP_RIM, 8'h00);
    take(4'h2, 16'hfff6);
    cc_chk(2'b00);
    wb(1'b1, a_ext, 8'h19);
    rd_chk(a_ext, 8'h11);
    cpu(NIC_OP_SIM, 8'h00);
    pulse_a();
    wb(1'b1, a_ext, 8'h19);
    cpu(NIC_OP_RIM, 8'h00);
    no_vec(12);
    $display("test external done");
    dly <= 2'h3;
    wb(1'b1, a_pr0 + 8'd4, 8'h7f);
    wb(1'b1, a_pr0 + 8'd8, 8'hfc);
    periph <= 7'h03;
    take(4'h8, 16'hffea);
    cc_chk(2'b00);
    no_vec(8);
    wb(1'b1, a_pr0 + 8'd8, 8'hff);
    take(4'h8, 16'hffea);
    cc_chk(2'b11);
    periph <= 7'h00;
    cpu(NIC_OP_IRQ_RETURN_INSTR, 8'h20);
    wb(1'b1, a_pr0 + 8'd4, 8'h3f);
    wb(1'b1, a_pr0 + 8'd8, 8'hfc);
    periph <= 7'h03;
    take(4'h7, 16'hffec);
    periph <= 7'h00;
    dly <= 2'h0;
    $display("test arbitration done");
    wake_chk(1'b0, 7'h02, 1'b0, 1'b0);
    wake_chk(1'b0, 7'h01, 1'b0, 1'b1);
    wake_chk(1'b0, 7'h40, 1'b0, 1'b1);
    wake_chk(1'b1, 7'h00, 1'b0, 1'b0);
    wake_chk(1'b1, 7'h00, 1'b1, 1'b1);
    $display("test wake done");
    conclude();
  end
endmodule : tb_nic_ctrl
